// ===== logic/arcu_top.sv
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none

module arcu_top
    import arcu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    output logic             cmd_done,
    output logic      [9:0]  cmd_errno,
    output logic      [1:0]  axis_running,
    output logic      [1:0]  axis_error,
    output logic      [1:0]  axis_aux_flag,
    output logic      [1:0]  step_pulse,
    output logic      [1:0]  step_dir
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [9:0] arcu_check(input logic [3:0] op, input logic run,
                                              input logic aux, input logic spdctl);
        logic [9:0] code;
        code = ERR_NONE;
        unique case (op)
            OP_START_POS, OP_START_SPD: code = run ? ERR_BUSY : ERR_NONE;
            OP_AUX_CANCEL:              code = aux ? ERR_NONE : ERR_NO_AUX;
            OP_SPD_OVR:                 code = run ? ERR_SPD_OVR : ERR_NONE;
            OP_TGT_OVR:                 code = run ? ERR_TGT_OVR : ERR_NONE;
            OP_POS_SPD:                 code = run ? ERR_POS_SPD : ERR_NONE;
            OP_SPD_TO_POS:
                code = run ? ERR_SW_RUN : (spdctl ? ERR_NONE : ERR_SW_NOSPD);
            OP_NONE, OP_STOP, OP_EMG, OP_ERR_CLR: code = ERR_NONE;
            default:                    code = ERR_BAD_OP;
        endcase
        return code;
    endfunction : arcu_check

    function automatic logic [31:0] arcu_speed(input logic pct, input logic [31:0] base,
                                               input logic [31:0] val);
        logic [47:0] prod;
        prod = 48'(base) * 48'(val[15:0]);
        return pct ? 32'(prod / PCT_FULL) : val;
    endfunction : arcu_speed

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic               ack_r;
    logic               wr_go;
    logic               rd_go;
    logic               cmd_go;
    logic [3:0]         cmd_op;
    logic               cmd_axis;
    logic [9:0]         cmd_code;
    logic [31:0]        ctrl_r;
    logic [31:0]        pa_r;
    logic [31:0]        pb_r;
    logic [31:0]        lastcmd_r;
    logic [31:0]        rd_mux;
    logic [31:0]        rdata_r;
    logic [IRQ_W-1:0]   irq_stat_r;
    logic [IRQ_W-1:0]   irq_mask_r;
    logic [IRQ_W-1:0]   irq_set;
    logic               done_r;
    logic [9:0]         errno_r;
    logic [1:0]         run_r;
    logic [1:0]         err_r;
    logic [1:0]         aux_r;
    logic [1:0]         spdctl_r;
    logic [1:0]         pend_r;
    logic [1:0]         step_r;
    logic [1:0]         dir_r;
    logic [7:0]         auxnum_r  [2];
    logic [7:0]         auxarm_r  [2];
    logic [9:0]         ecode_r   [2];
    logic signed [31:0] pos_r     [2];
    logic signed [31:0] tgt_r     [2];
    logic signed [31:0] trig_r    [2];
    logic [31:0]        spd_r     [2];
    logic [31:0]        base_r    [2];
    logic [31:0]        pspd_r    [2];
    logic [31:0]        acc_r     [2];
    logic [32:0]        acc_sum   [2];
    logic [1:0]         step_due;
    logic [1:0]         at_tgt;
    logic [1:0]         arrive;
    logic [1:0]         trig_hit;
    logic [31:0]        stat_word [2];

    // ----------------------------------------------------------------
    // avalon slave: one wait state on every access
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read | avs_write) & ~ack_r;
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go           = avs_write & ack_r;
    assign rd_go           = avs_read & ack_r;
    assign cmd_go          = wr_go && (avs_address == OFS_CMD);
    assign cmd_op          = avs_writedata[3:0];
    assign cmd_axis        = avs_writedata[CMD_AXIS_BIT];
    assign cmd_code        = (cmd_op == OP_EMG) ? ERR_NONE :
                             arcu_check(cmd_op, run_r[cmd_axis], aux_r[cmd_axis], spdctl_r[cmd_axis]);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_r     <= RST_WORD;
            pa_r       <= RST_WORD;
            pb_r       <= RST_WORD;
            lastcmd_r  <= RST_WORD;
            irq_mask_r <= '0;
        end
        else if (wr_go)
        begin
            unique case (avs_address)
                OFS_CTRL:     ctrl_r     <= {31'h00000000, avs_writedata[CTRL_PCT_BIT]};
                OFS_PARAM_A:  pa_r       <= avs_writedata;
                OFS_PARAM_B:  pb_r       <= avs_writedata;
                OFS_CMD:      lastcmd_r  <= {16'h0000, avs_writedata[15:0]};
                OFS_IRQ_MASK: irq_mask_r <= avs_writedata[IRQ_W-1:0];
                default:      ;
            endcase
        end
    end

    always_comb
    begin
        unique case (avs_address)
            OFS_CTRL:     rd_mux = ctrl_r;
            OFS_PARAM_A:  rd_mux = pa_r;
            OFS_PARAM_B:  rd_mux = pb_r;
            OFS_CMD:      rd_mux = lastcmd_r;
            OFS_RESULT:   rd_mux = {6'h00, errno_r, 15'h0000, done_r};
            OFS_STAT_X:   rd_mux = stat_word[0];
            OFS_STAT_Y:   rd_mux = stat_word[1];
            OFS_POS_X:    rd_mux = pos_r[0];
            OFS_POS_Y:    rd_mux = pos_r[1];
            OFS_IRQ_STAT: rd_mux = {26'h0000000, irq_stat_r};
            OFS_IRQ_MASK: rd_mux = {26'h0000000, irq_mask_r};
            default:      rd_mux = RST_WORD;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_r <= RST_WORD;
        else if (avs_read && !ack_r)
            rdata_r <= rd_mux;
    end

    assign avs_readdata = rdata_r;

    // ----------------------------------------------------------------
    // interrupt status, cleared by reading the bits that were returned
    // ----------------------------------------------------------------
    assign irq_set = {trig_hit, arrive, cmd_go && (cmd_code != ERR_NONE),
                      cmd_go && (cmd_code == ERR_NONE)};

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_stat_r <= '0;
        else if (rd_go && (avs_address == OFS_IRQ_STAT))
            irq_stat_r <= (irq_stat_r & ~rdata_r[IRQ_W-1:0]) | irq_set;
        else
            irq_stat_r <= irq_stat_r | irq_set;
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------------------------------
    // command result
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done_r  <= 1'b0;
            errno_r <= ERR_NONE;
        end
        else if (cmd_go)
        begin
            done_r  <= (cmd_code == ERR_NONE);
            errno_r <= cmd_code;
        end
    end

    assign cmd_done  = done_r;
    assign cmd_errno = errno_r;

    // ----------------------------------------------------------------
    // per-axis pulse generation
    // ----------------------------------------------------------------
    for (genvar a = 0; a < 2; a++)
    begin : g_axis
        assign acc_sum[a]   = {1'b0, acc_r[a]} + {1'b0, spd_r[a]};
        assign at_tgt[a]    = (pos_r[a] == tgt_r[a]);
        assign step_due[a]  = run_r[a] && (acc_sum[a] >= CLK_HZ_W) && (spdctl_r[a] || !at_tgt[a]);
        assign arrive[a]    = run_r[a] && !spdctl_r[a] && at_tgt[a];
        assign trig_hit[a]  = pend_r[a] && (pos_r[a] == trig_r[a]);
        assign stat_word[a] = {6'h00, ecode_r[a], auxnum_r[a], 3'h0, pend_r[a],
                               spdctl_r[a], aux_r[a], err_r[a], run_r[a]};
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            step_r <= '0;
            dir_r  <= '0;
            for (int a = 0; a < 2; a++)
            begin
                acc_r[a] <= RST_WORD;
                pos_r[a] <= '0;
            end
        end
        else
        begin
            for (int a = 0; a < 2; a++)
            begin
                step_r[a] <= step_due[a];
                if (!run_r[a])
                    acc_r[a] <= RST_WORD;
                else if (step_due[a])
                begin
                    acc_r[a] <= 32'(acc_sum[a] - CLK_HZ_W);
                    if (spdctl_r[a] || (tgt_r[a] > pos_r[a]))
                    begin
                        pos_r[a] <= pos_r[a] + 32'sd1;
                        dir_r[a] <= 1'b1;
                    end
                    else
                    begin
                        pos_r[a] <= pos_r[a] - 32'sd1;
                        dir_r[a] <= 1'b0;
                    end
                end
                else
                    acc_r[a] <= acc_sum[a][31:0];
            end
        end
    end

    assign step_pulse = step_r;
    assign step_dir   = dir_r;

    // ----------------------------------------------------------------
    // per-axis state and command execution
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_r    <= '0;
            err_r    <= '0;
            aux_r    <= '0;
            spdctl_r <= '0;
            pend_r   <= '0;
            for (int a = 0; a < 2; a++)
            begin
                auxnum_r[a] <= 8'h00;
                auxarm_r[a] <= 8'h00;
                ecode_r[a]  <= ERR_NONE;
                tgt_r[a]    <= '0;
                trig_r[a]   <= '0;
                spd_r[a]    <= RST_WORD;
                base_r[a]   <= RST_WORD;
                pspd_r[a]   <= RST_WORD;
            end
        end
        else
        begin
            for (int a = 0; a < 2; a++)
            begin
                if (arrive[a])
                    run_r[a] <= 1'b0;
                if (trig_hit[a])
                begin
                    spd_r[a]  <= pspd_r[a];
                    pend_r[a] <= 1'b0;
                end
                if (cmd_go && (cmd_op == OP_EMG))
                begin
                    run_r[a]   <= 1'b0;
                    pend_r[a]  <= 1'b0;
                    err_r[a]   <= 1'b1;
                    ecode_r[a] <= ERR_EMG;
                end
                else if (cmd_go && (cmd_axis == 1'(a)))
                begin
                    if (cmd_code != ERR_NONE)
                    begin
                        err_r[a]   <= 1'b1;
                        ecode_r[a] <= cmd_code;
                    end
                    else
                    begin
                        unique case (cmd_op)
                            OP_START_POS:
                            begin
                                run_r[a]    <= 1'b1;
                                spdctl_r[a] <= 1'b0;
                                tgt_r[a]    <= pa_r;
                                base_r[a]   <= pb_r;
                                spd_r[a]    <= pb_r;
                                auxarm_r[a] <= avs_writedata[CMD_AUX_LSB +: 8];
                            end
                            OP_START_SPD:
                            begin
                                run_r[a]    <= 1'b1;
                                spdctl_r[a] <= 1'b1;
                                base_r[a]   <= pb_r;
                                spd_r[a]    <= pb_r;
                                auxarm_r[a] <= 8'h00;
                            end
                            OP_STOP:
                                run_r[a] <= 1'b0;
                            OP_AUX_CANCEL:
                            begin
                                aux_r[a]    <= 1'b0;
                                auxnum_r[a] <= 8'h00;
                            end
                            OP_SPD_OVR:
                                spd_r[a] <= arcu_speed(ctrl_r[CTRL_PCT_BIT], base_r[a], pb_r);
                            OP_TGT_OVR:
                                tgt_r[a] <= pa_r;
                            OP_POS_SPD:
                            begin
                                pspd_r[a] <= arcu_speed(ctrl_r[CTRL_PCT_BIT], base_r[a], pb_r);
                                trig_r[a] <= pa_r;
                                pend_r[a] <= 1'b1;
                            end
                            OP_SPD_TO_POS:
                            begin
                                spdctl_r[a] <= 1'b0;
                                tgt_r[a]    <= pos_r[a] + $signed(pa_r);
                            end
                            OP_ERR_CLR:
                            begin
                                err_r[a]   <= 1'b0;
                                ecode_r[a] <= ERR_NONE;
                            end
                            default: ;
                        endcase
                    end
                end
                if (arrive[a] && (auxarm_r[a] != 8'h00))
                begin
                    aux_r[a]    <= 1'b1;
                    auxnum_r[a] <= auxarm_r[a];
                end
            end
        end
    end

    assign axis_running  = run_r;
    assign axis_error    = err_r;
    assign axis_aux_flag = aux_r;

endmodule : arcu_top

`default_nettype wire

// ===== logic/arcu_pkg.sv
package arcu_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam logic [32:0] CLK_HZ_W    = 33'(CLK_HZ);
    localparam logic [47:0] PCT_FULL    = 48'h000000002710;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PARAM_A  = 8'h04;
    localparam logic [7:0] OFS_PARAM_B  = 8'h08;
    localparam logic [7:0] OFS_CMD      = 8'h0c;
    localparam logic [7:0] OFS_RESULT   = 8'h10;
    localparam logic [7:0] OFS_STAT_X   = 8'h14;
    localparam logic [7:0] OFS_STAT_Y   = 8'h18;
    localparam logic [7:0] OFS_POS_X    = 8'h1c;
    localparam logic [7:0] OFS_POS_Y    = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_PCT_BIT   = 0;
    localparam int CMD_AXIS_BIT   = 4;
    localparam int CMD_AUX_LSB    = 8;
    localparam int RES_ERR_LSB    = 16;
    localparam int ST_RUN_BIT     = 0;
    localparam int ST_ERR_BIT     = 1;
    localparam int ST_AUX_BIT     = 2;
    localparam int ST_SPD_BIT     = 3;
    localparam int ST_PEND_BIT    = 4;
    localparam int ST_AUXNUM_LSB  = 8;
    localparam int ST_ECODE_LSB   = 16;
    localparam int IRQ_W          = 6;
    localparam int IRQ_OK_BIT     = 0;
    localparam int IRQ_FAIL_BIT   = 1;
    localparam int IRQ_ARRIVE_LSB = 2;
    localparam int IRQ_TRIG_LSB   = 4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [9:0]  ERR_NONE = 10'h000;

    // ----------------------------------------------------------------
    // error numbers
    // ----------------------------------------------------------------
    localparam logic [9:0] ERR_EMG       = 10'h1e1;
    localparam logic [9:0] ERR_SPD_OVR   = 10'h173;
    localparam logic [9:0] ERR_TGT_OVR   = 10'h169;
    localparam logic [9:0] ERR_POS_SPD   = 10'h17d;
    localparam logic [9:0] ERR_SW_RUN    = 10'h12d;
    localparam logic [9:0] ERR_SW_NOSPD  = 10'h12e;
    localparam logic [9:0] ERR_BUSY      = 10'h001;
    localparam logic [9:0] ERR_NO_AUX    = 10'h002;
    localparam logic [9:0] ERR_BAD_OP    = 10'h003;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE       = 4'h0,
        OP_START_POS  = 4'h1,
        OP_START_SPD  = 4'h2,
        OP_STOP       = 4'h3,
        OP_EMG        = 4'h4,
        OP_AUX_CANCEL = 4'h5,
        OP_SPD_OVR    = 4'h6,
        OP_TGT_OVR    = 4'h7,
        OP_POS_SPD    = 4'h8,
        OP_SPD_TO_POS = 4'h9,
        OP_ERR_CLR    = 4'ha
    } arcu_op_e;

endpackage : arcu_pkg

// ===== dv/arcu_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module arcu_host_model
(
    input  wire logic        clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata
);
    // ----------------------------------------
    // host bus master, one transfer at a time
    // ----------------------------------------
    initial
    begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
    end

    task automatic xfer(input logic rnw, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rnw;
        avs_write <= !rnw;
        // hold the request until waitrequest is seen low at a rising edge
        do
            @(posedge clk);
        while (avs_waitrequest);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer
endmodule : arcu_host_model
`default_nettype wire

// ===== dv/arcu_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module arcu_top_props
    import arcu_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        irq,
    input wire logic        cmd_done,
    input wire logic [9:0]  cmd_errno,
    input wire logic [1:0]  axis_running,
    input wire logic [1:0]  axis_error,
    input wire logic [1:0]  axis_aux_flag,
    input wire logic [1:0]  step_pulse,
    input wire logic [1:0]  step_dir
);
    // ----------------------------------------
    // command outcome checks
    // ----------------------------------------
    logic       go;
    logic [3:0] op;
    logic       ax;
    assign go = avs_write && !avs_waitrequest && avs_address == OFS_CMD;
    assign op = avs_writedata[3:0];
    assign ax = avs_writedata[4];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_emg; go && op == OP_EMG |=> axis_error == 2'b11 && axis_running == 2'b00; endproperty
    a_emg: assert property (p_emg) else $error("stop not on both axes");
    property p_cancel; go && op == OP_AUX_CANCEL && axis_aux_flag[ax] && !axis_running[ax]
        |=> !axis_aux_flag[$past(ax)]; endproperty
    a_cancel: assert property (p_cancel) else $error("aux flag kept");
    property p_noaux; go && op == OP_AUX_CANCEL && !axis_aux_flag[ax] |=> cmd_errno == ERR_NO_AUX; endproperty
    a_noaux: assert property (p_noaux) else $error("cancel without flag taken");
    property p_spd; go && op == OP_SPD_OVR && axis_running[ax] |=> !cmd_done && cmd_errno == ERR_SPD_OVR; endproperty
    a_spd: assert property (p_spd) else $error("speed change not refused");
    property p_tgt; go && op == OP_TGT_OVR && axis_running[ax] |=> cmd_errno == ERR_TGT_OVR && axis_error[$past(ax)];
    endproperty
    a_tgt: assert property (p_tgt) else $error("target change not refused");
    property p_trg; go && op == OP_POS_SPD && axis_running[ax] |=> !cmd_done && cmd_errno == ERR_POS_SPD; endproperty
    a_trg: assert property (p_trg) else $error("trigger change not refused");
    property p_sw; go && op == OP_SPD_TO_POS && axis_running[ax] |=> cmd_errno == ERR_SW_RUN; endproperty
    a_sw: assert property (p_sw) else $error("switch not refused");
    property p_done; go |=> cmd_done == (cmd_errno == ERR_NONE); endproperty
    a_done: assert property (p_done) else $error("done and error disagree");
    property p_hold; !go |=> $stable(cmd_done) && $stable(cmd_errno); endproperty
    a_hold: assert property (p_hold) else $error("result moved without command");
endmodule : arcu_top_props

bind arcu_top arcu_top_props i_arcu_top_props (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .cmd_done(cmd_done), .cmd_errno(cmd_errno),
    .axis_running(axis_running), .axis_error(axis_error), .axis_aux_flag(axis_aux_flag),
    .step_pulse(step_pulse), .step_dir(step_dir));
`default_nettype wire

// ===== dv/test_arcu_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_arcu_top
    import arcu_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest, irq, cmd_done;
    logic [31:0] avs_writedata, avs_readdata, q, p;
    logic [9:0]  cmd_errno;
    logic [1:0]  axis_running, axis_error, axis_aux_flag, step_pulse, step_dir;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #25 clk = ~clk;

    arcu_top i_arcu_top (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .cmd_done(cmd_done), .cmd_errno(cmd_errno),
        .axis_running(axis_running), .axis_error(axis_error), .axis_aux_flag(axis_aux_flag),
        .step_pulse(step_pulse), .step_dir(step_dir));
    arcu_host_model i_arcu_host_model (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_arcu_host_model.xfer(1'b0, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        i_arcu_host_model.xfer(1'b1, a, 32'h0, q);
    endtask : rd

    task automatic cmd(input logic [31:0] a, b, input logic [3:0] op, input logic ax, input logic [7:0] m,
                       input logic [9:0] e);
        wr(OFS_PARAM_A, a);
        wr(OFS_PARAM_B, b);
        wr(OFS_CMD, {16'h0, m, 3'h0, ax, op});
        @(negedge clk);
        chk("cmd_done", cmd_done, e == ERR_NONE);
        chk("cmd_errno", cmd_errno, e);
    endtask : cmd

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(OFS_RESULT);
        chk("result", q, 0);
        rd(8'h3c);
        chk("unmapped", q, 0);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL);
        chk("ctrl", q, 1);
    endtask : t_reset

    task automatic t_busy;
        logic [3:0] ops [4] = '{OP_SPD_OVR, OP_TGT_OVR, OP_POS_SPD, OP_SPD_TO_POS};
        logic [9:0] errs [4] = '{ERR_SPD_OVR, ERR_TGT_OVR, ERR_POS_SPD, ERR_SW_RUN};
        wr(OFS_IRQ_MASK, 32'h2);
        cmd(0, 32'd2000000, OP_START_SPD, 1'b0, 8'h0, ERR_NONE);
        chk("irq_masked", irq, 0);
        for (int i = 0; i < 4; i++)
        begin
            cmd(0, 32'd1000, ops[i], 1'b0, 8'h0, errs[i]);
            chk("err_flag", axis_error, 1);
            chk("running", axis_running, 1);
        end
        chk("irq", irq, 1);
        rd(OFS_IRQ_STAT);
        chk("irq_stat", q[1], 1);
        @(negedge clk);
        chk("irq_clr", irq, 0);
        rd(OFS_STAT_Y);
        chk("stat_y", q, 0);
    endtask : t_busy

    task automatic t_switch;
        cmd(0, 0, OP_ERR_CLR, 1'b0, 8'h0, ERR_NONE);
        cmd(0, 0, OP_STOP, 1'b0, 8'h0, ERR_NONE);
        cmd(20, 0, OP_SPD_TO_POS, 1'b1, 8'h0, ERR_SW_NOSPD);
        cmd(0, 0, OP_ERR_CLR, 1'b1, 8'h0, ERR_NONE);
        cmd(5, 0, OP_SPD_TO_POS, 1'b0, 8'h0, ERR_NONE);
        cmd(0, 0, 4'hf, 1'b0, 8'h0, ERR_BAD_OP);
        cmd(0, 0, OP_ERR_CLR, 1'b0, 8'h0, ERR_NONE);
    endtask : t_switch

    task automatic t_aux;
        for (int i = 0; i < 500 && axis_running[0]; i++) @(negedge clk);
        cmd(0, 0, OP_AUX_CANCEL, 1'b0, 8'h0, ERR_NO_AUX);
        cmd(0, 0, OP_ERR_CLR, 1'b0, 8'h0, ERR_NONE);
        rd(OFS_POS_X);
        p = q + 32'd16;
        cmd(p, 32'd4000000, OP_START_POS, 1'b0, 8'h5a, ERR_NONE);
        for (int i = 0; i < 500 && axis_running[0]; i++) @(negedge clk);
        chk("aux_flag", axis_aux_flag, 1);
        rd(OFS_POS_X);
        chk("pos_x", q, p);
        rd(OFS_STAT_X);
        chk("aux_num", q[15:8], 8'h5a);
        cmd(0, 0, OP_AUX_CANCEL, 1'b0, 8'h0, ERR_NONE);
        chk("aux_off", axis_aux_flag, 0);
        rd(OFS_STAT_X);
        chk("aux_zero", q[15:8], 0);
    endtask : t_aux

    task automatic t_trig;
        cmd(0, 32'd5000, OP_SPD_OVR, 1'b1, 8'h0, ERR_NONE);
        wr(OFS_CTRL, 32'h0);
        rd(OFS_POS_Y);
        p = q + 32'd30;
        cmd(p, 32'd4000000, OP_POS_SPD, 1'b1, 8'h0, ERR_NONE);
        rd(OFS_STAT_Y);
        chk("pending", q[4], 1);
        wr(OFS_IRQ_MASK, 32'h20);
        cmd(0, 32'd1000000, OP_START_SPD, 1'b1, 8'h0, ERR_NONE);
        for (int i = 0; i < 2000 && !irq; i++) @(negedge clk);
        rd(OFS_POS_Y);
        chk("trig_pos", q - p <= 32'd1, 1);
        rd(OFS_STAT_Y);
        chk("applied", q[4], 0);
        chk("step_dir", step_dir, 3);
    endtask : t_trig

    task automatic t_emg;
        int n;
        n = 0;
        cmd(0, 0, OP_EMG, 1'b0, 8'h0, ERR_NONE);
        chk("emg_err", axis_error, 3);
        chk("emg_run", axis_running, 0);
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk);
            n += (step_pulse != 2'b00);
        end
        chk("emg_steps", n, 0);
        rd(OFS_STAT_X);
        chk("code_x", q[25:16], ERR_EMG);
        rd(OFS_STAT_Y);
        chk("code_y", q[25:16], ERR_EMG);
    endtask : t_emg

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_busy();
        t_switch();
        t_aux();
        t_trig();
        t_emg();
        tally_and_finish();
    end
endmodule : test_arcu_top
`default_nettype wire
